//--- common/bcs_cal_if.sv
// link between the register bank and the calibration engine
`timescale 1ns/100ps
interface bcs_cal_if;
  logic avg_valid;
  logic [7:0] avg;
  logic run;
  logic narrow;
  logic [7:0] dac0;
  logic [7:0] dac1;
  modport regs (output avg_valid, output avg, output run, output narrow,
                input dac0, input dac1);
  modport eng (input avg_valid, input avg, input run, input narrow,
               output dac0, output dac1);
endinterface : bcs_cal_if

//--- common/bcs_pkg.sv
// constants and types shared by the black calibration system register bank
package bcs_pkg;
  // register indexes, seven bits wide
  localparam logic [6:0] IDX_SETUP = 7'h70;
  localparam logic [6:0] IDX_DAC0 = 7'h71;
  localparam logic [6:0] IDX_DAC1 = 7'h72;
  localparam logic [6:0] IDX_TEST = 7'h74;
  localparam logic [6:0] IDX_AC0 = 7'h76;
  localparam logic [6:0] IDX_AC1 = 7'h77;
  localparam logic [6:0] IDX_RESET = 7'h00;
  // writable bit masks
  localparam logic [7:0] SETUP_MASK = 8'h7f;
  localparam logic [7:0] TEST_MASK = 8'h0a;
  localparam logic [7:0] AC0_MASK = 8'hbf;
  localparam logic [7:0] AC1_MASK = 8'hef;
  // reset values
  localparam logic [7:0] SETUP_RESET = 8'h01;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] AC0_RESET = 8'h00;
  localparam logic [7:0] AC1_RESET = 8'h00;
  localparam logic [7:0] DAC_RESET = 8'h80;
  // field positions
  localparam int SETUP_WIN_LSB = 2;
  localparam int SETUP_WIN_USER = 4;
  localparam int SETUP_NARROW = 5;
  localparam int SETUP_EXT = 6;
  localparam int TEST_TRI_HI = 1;
  localparam int TEST_TRI_LO = 3;
  localparam int AC0_BLANK_INH = 5;
  localparam int AC0_CLK_SEL = 7;
  localparam int AC1_DBL = 0;
  localparam int AC1_ALT = 1;
  localparam int AC1_HG = 2;
  localparam int AC1_STBY = 3;
  localparam int AC1_PH_LSB = 5;
  // black line averaging
  localparam logic [7:0] PIX_FIRST = 8'h12;
  localparam logic [7:0] PIX_LAST_ACC = 8'h7f;
  localparam logic [7:0] AVG_IDEAL = 8'h10;
  localparam logic [7:0] MON_LO_BASE = 8'h0e;
  localparam logic [7:0] MON_HI_BASE = 8'h11;
  localparam logic [7:0] TGT_LO = 8'h0f;
  localparam logic [7:0] TGT_HI = 8'h11;
  localparam logic [7:0] TGT_NARROW_LO = 8'h10;
  localparam logic [7:0] TGT_NARROW_HI = 8'h10;
  typedef enum logic [1:0] {
    TRIG_NEVER = 2'h0,
    TRIG_ALWAYS = 2'h1,
    TRIG_MONITOR = 2'h2,
    TRIG_GAIN = 2'h3
  } bcs_trig_type;
  typedef enum logic {
    PH_SAR = 1'b0,
    PH_TRACK = 1'b1
  } bcs_phase_type;
endpackage : bcs_pkg

//--- design/bcs_dac_calib.sv
// two phase offset dac calibration engine
`timescale 1ns/100ps
module bcs_dac_calib (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bank side
  bcs_cal_if.eng cal
);
  typedef struct packed {
    bcs_pkg::bcs_phase_type phase;
    logic sel;
    logic [2:0] bit_idx;
    logic [7:0] dac0;
    logic [7:0] dac1;
  } bcs_cal_state_type;

  bcs_cal_state_type st_ff;
  bcs_cal_state_type nxt_st;
  logic [7:0] tgt_lo;
  logic [7:0] tgt_hi;
  logic [7:0] code;

  always_comb begin
    nxt_st = st_ff;
    tgt_lo = cal.narrow ? bcs_pkg::TGT_NARROW_LO : bcs_pkg::TGT_LO;
    tgt_hi = cal.narrow ? bcs_pkg::TGT_NARROW_HI : bcs_pkg::TGT_HI;
    code = st_ff.sel ? st_ff.dac1 : st_ff.dac0;
    if (cal.avg_valid && cal.run) begin
      unique case (st_ff.phase)
        // a higher code raises the black level, so a high average drops the trial bit
        bcs_pkg::PH_SAR: begin
          if (cal.avg > bcs_pkg::AVG_IDEAL) begin
            code[st_ff.bit_idx] = 1'b0;
          end
          if (st_ff.bit_idx != 3'h0) begin
            nxt_st.bit_idx = st_ff.bit_idx - 3'h1;
            code[st_ff.bit_idx - 3'h1] = 1'b1;
          end else begin
            nxt_st.bit_idx = 3'h7;
            nxt_st.sel = ~st_ff.sel;
            if (st_ff.sel) begin
              nxt_st.phase = bcs_pkg::PH_TRACK;
            end
          end
        end
        bcs_pkg::PH_TRACK: begin
          if (cal.avg < tgt_lo && code != 8'hff) begin
            code = code + 8'h01;
          end else if (cal.avg > tgt_hi && code != 8'h00) begin
            code = code - 8'h01;
          end
          nxt_st.sel = ~st_ff.sel;
        end
      endcase
      if (st_ff.sel) begin
        nxt_st.dac1 = code;
      end else begin
        nxt_st.dac0 = code;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{phase: bcs_pkg::PH_SAR, sel: 1'b0, bit_idx: 3'h7,
                 dac0: bcs_pkg::DAC_RESET, dac1: bcs_pkg::DAC_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cal.dac0 = st_ff.dac0;
  assign cal.dac1 = st_ff.dac1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_last_trial;
    cal.avg_valid && cal.run && st_ff.phase == bcs_pkg::PH_SAR &&
      st_ff.bit_idx == 3'h0 && st_ff.sel;
  endsequence
  property p_sar_done;
    s_last_trial |=> st_ff.phase == bcs_pkg::PH_TRACK && st_ff.bit_idx == 3'h7;
  endproperty
  a_sar_done: assert property (p_sar_done) else $error("search did not end in tracking");

  property p_track_hold;
    (st_ff.phase == bcs_pkg::PH_TRACK && !(cal.avg_valid && cal.run))
      |=> $stable(st_ff.dac0) && $stable(st_ff.dac1);
  endproperty
  a_track_hold: assert property (p_track_hold) else $error("dac moved without a step");

  property p_track_inside;
    (st_ff.phase == bcs_pkg::PH_TRACK && cal.avg_valid && cal.run &&
      cal.avg >= tgt_lo && cal.avg <= tgt_hi) |=> $stable(st_ff.dac0) && $stable(st_ff.dac1);
  endproperty
  a_track_inside: assert property (p_track_inside) else $error("dac stepped inside target");
endmodule : bcs_dac_calib

//--- design/bcs_rst_delay.sv
// reset timing pair delay, counted in converter clock periods
`timescale 1ns/100ps
module bcs_rst_delay (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // converter clocks from pins
  input wire logic conv_a_i,
  input wire logic conv_b_i,
  // control
  input wire logic sel_b_i,
  input wire logic [2:0] delay_i,
  // timing pair
  input wire logic [1:0] rtp_i,
  output logic [1:0] rtp_o
);
  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic prev;
    logic [6:0][1:0] line;
    logic [1:0] out;
  } bcs_dly_state_type;

  bcs_dly_state_type st_ff;
  bcs_dly_state_type nxt_st;
  logic cur;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync_a = {st_ff.sync_a[0], conv_a_i};
    nxt_st.sync_b = {st_ff.sync_b[0], conv_b_i};
    cur = sel_b_i ? st_ff.sync_b[1] : st_ff.sync_a[1];
    nxt_st.prev = cur;
    // a select change may fake one edge; the delay is only meaningful once settled
    if (cur && !st_ff.prev) begin
      nxt_st.line = {st_ff.line[5:0], rtp_i};
    end
    if (delay_i == 3'h0) begin
      nxt_st.out = rtp_i;
    end else begin
      nxt_st.out = st_ff.line[delay_i - 3'h1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rtp_o = st_ff.out;

  property p_no_delay;
    @(posedge clk_i) disable iff (rst_i) (delay_i == 3'h0) |=> rtp_o == $past(rtp_i);
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("undelayed pair mismatch");
endmodule : bcs_rst_delay

//--- design/bcs_system_regs.sv
// system register bank with black level averaging, test tristates and analogue controls
`timescale 1ns/100ps
module bcs_system_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte register port from serial interface
  input wire logic idx_wr_i,
  input wire logic [7:0] idx_byte_i,
  input wire logic wr_byte_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_byte_i,
  output logic [7:0] rd_data_o,
  // pixel stream and gain
  input wire logic line_start_i,
  input wire logic black_line_i,
  input wire logic pix_valid_i,
  input wire logic [7:0] pix_i,
  input wire logic [2:0] gain_i,
  // external dac values and dac codes to core
  input wire logic [7:0] ext_dac0_i,
  input wire logic [7:0] ext_dac1_i,
  output logic [7:0] first_offset_dac_o,
  output logic [7:0] second_offset_dac_o,
  // video outputs with enables
  input wire logic [7:0] vid_data_i,
  input wire logic frame_start_strobe_i,
  input wire logic qualifier_clock_i,
  output logic [7:0] data_o,
  output logic [7:0] data_oe_o,
  output logic frame_start_strobe_o,
  output logic frame_start_strobe_oe_o,
  output logic qualifier_clock_o,
  output logic qualifier_clock_oe_o,
  // analogue controls
  input wire logic blank_line_i,
  input wire logic array_read_strobe_a_i,
  input wire logic array_read_strobe_b_i,
  output logic [5:0] ana_ctrl_o,
  output logic array_read_strobe_a_o,
  output logic array_read_strobe_b_o,
  output logic dac0_double_current_o,
  output logic alt_pixel_readout_scheme_o,
  output logic dac1_high_gain_o,
  output logic standby_o,
  // reset timing pair
  input wire logic converter_clock_a_i,
  input wire logic converter_clock_b_i,
  input wire logic [1:0] reset_timing_pair_i,
  output logic [1:0] reset_timing_pair_o
);
  typedef struct packed {
    logic [6:0] idx;
    logic inc;
    logic [7:0] setup;
    logic [7:0] test;
    logic [7:0] ac0;
    logic [7:0] ac1;
    logic [7:0] rd_data;
    logic [7:0] pix_cnt;
    logic [7:0] acc_cnt;
    logic [14:0] sum;
    logic avg_valid;
    logic [7:0] avg;
    logic run;
    logic [2:0] gain_last;
    logic [7:0] dac0_out;
    logic [7:0] dac1_out;
    logic [7:0] data;
    logic [7:0] data_oe;
    logic frame_start_strobe;
    logic fst_oe;
    logic qualifier_clock;
    logic qck_oe;
    logic strobe_a;
    logic strobe_b;
  } bcs_regs_state_type;

  bcs_regs_state_type st_ff;
  bcs_regs_state_type nxt_st;
  bcs_cal_if cal_if ();

  logic [7:0] rd_mux;
  logic [14:0] sum_new;
  logic [7:0] avg_new;
  logic acc_take;
  logic acc_done;
  logic [1:0] win_sel;
  logic [7:0] mon_lo;
  logic [7:0] mon_hi;
  logic outside;
  logic run_now;
  bcs_pkg::bcs_trig_type trig;

  // read data, reserved and unused bits are zero through the stored masks
  always_comb begin
    case (st_ff.idx)
      bcs_pkg::IDX_SETUP: rd_mux = st_ff.setup;
      bcs_pkg::IDX_DAC0: rd_mux = cal_if.dac0;
      bcs_pkg::IDX_DAC1: rd_mux = cal_if.dac1;
      bcs_pkg::IDX_TEST: rd_mux = st_ff.test;
      bcs_pkg::IDX_AC0: rd_mux = st_ff.ac0;
      bcs_pkg::IDX_AC1: rd_mux = st_ff.ac1;
      default: rd_mux = 8'h00;
    endcase
  end

  // central pixel accumulation on black lines
  always_comb begin
    acc_take = pix_valid_i && black_line_i && !line_start_i &&
               st_ff.pix_cnt >= bcs_pkg::PIX_FIRST && !st_ff.acc_cnt[7];
    acc_done = acc_take && st_ff.acc_cnt == bcs_pkg::PIX_LAST_ACC;
    sum_new = st_ff.sum + {7'h00, pix_i};
    avg_new = sum_new[14:7];
  end

  // monitor window and trigger decision
  always_comb begin
    if (st_ff.setup[bcs_pkg::SETUP_WIN_USER]) begin
      win_sel = st_ff.setup[bcs_pkg::SETUP_WIN_LSB +: 2];
    end else begin
      // each set gain bit amplifies the offset noise, so it widens the window by one step
      win_sel = {1'b0, gain_i[0]} + {1'b0, gain_i[1]} + {1'b0, gain_i[2]};
      if (gain_i == 3'h7) begin
        win_sel = 2'h3;
      end
    end
    mon_lo = bcs_pkg::MON_LO_BASE - {6'h00, win_sel};
    mon_hi = bcs_pkg::MON_HI_BASE + {6'h00, win_sel};
    outside = avg_new < mon_lo || avg_new > mon_hi;
    trig = bcs_pkg::bcs_trig_type'(st_ff.setup[1:0]);
    unique case (trig)
      bcs_pkg::TRIG_NEVER: run_now = 1'b0;
      bcs_pkg::TRIG_ALWAYS: run_now = 1'b1;
      bcs_pkg::TRIG_MONITOR: run_now = outside;
      bcs_pkg::TRIG_GAIN: run_now = gain_i != st_ff.gain_last;
    endcase
    if (st_ff.ac1[bcs_pkg::AC1_STBY]) begin
      run_now = 1'b0;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.avg_valid = 1'b0;
    nxt_st.run = 1'b0;
    if (idx_wr_i) begin
      nxt_st.idx = idx_byte_i[6:0];
      nxt_st.inc = idx_byte_i[7];
    end else if (wr_byte_i || rd_byte_i) begin
      if (wr_byte_i) begin
        case (st_ff.idx)
          bcs_pkg::IDX_SETUP: nxt_st.setup = wr_data_i & bcs_pkg::SETUP_MASK;
          bcs_pkg::IDX_TEST: nxt_st.test = wr_data_i & bcs_pkg::TEST_MASK;
          bcs_pkg::IDX_AC0: nxt_st.ac0 = wr_data_i & bcs_pkg::AC0_MASK;
          bcs_pkg::IDX_AC1: nxt_st.ac1 = wr_data_i & bcs_pkg::AC1_MASK;
          default: nxt_st.idx = st_ff.idx;
        endcase
      end
      if (rd_byte_i) begin
        nxt_st.rd_data = rd_mux;
      end
      if (st_ff.inc) begin
        nxt_st.idx = st_ff.idx + 7'h01;
      end
    end
    if (line_start_i) begin
      nxt_st.pix_cnt = 8'h00;
      nxt_st.acc_cnt = 8'h00;
      nxt_st.sum = 15'h0000;
    end else if (pix_valid_i && black_line_i) begin
      if (st_ff.pix_cnt != 8'hff) begin
        nxt_st.pix_cnt = st_ff.pix_cnt + 8'h01;
      end
      if (acc_take) begin
        nxt_st.sum = sum_new;
        nxt_st.acc_cnt = st_ff.acc_cnt + 8'h01;
      end
    end
    if (acc_done) begin
      nxt_st.avg_valid = 1'b1;
      nxt_st.avg = avg_new;
      nxt_st.run = run_now;
      if (run_now) begin
        nxt_st.gain_last = gain_i;
      end
    end
    if (st_ff.setup[bcs_pkg::SETUP_EXT]) begin
      nxt_st.dac0_out = ext_dac0_i;
      nxt_st.dac1_out = ext_dac1_i;
    end else begin
      nxt_st.dac0_out = cal_if.dac0;
      nxt_st.dac1_out = cal_if.dac1;
    end
    nxt_st.data = vid_data_i;
    nxt_st.frame_start_strobe = frame_start_strobe_i;
    nxt_st.qualifier_clock = qualifier_clock_i;
    nxt_st.data_oe[7:4] = {4{~st_ff.test[bcs_pkg::TEST_TRI_HI]}};
    nxt_st.fst_oe = ~st_ff.test[bcs_pkg::TEST_TRI_HI];
    nxt_st.qck_oe = ~st_ff.test[bcs_pkg::TEST_TRI_HI];
    nxt_st.data_oe[3:0] = {4{~st_ff.test[bcs_pkg::TEST_TRI_LO]}};
    nxt_st.strobe_a = array_read_strobe_a_i &
                      ~(st_ff.ac0[bcs_pkg::AC0_BLANK_INH] & blank_line_i);
    nxt_st.strobe_b = array_read_strobe_b_i &
                      ~(st_ff.ac0[bcs_pkg::AC0_BLANK_INH] & blank_line_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.idx <= bcs_pkg::IDX_RESET;
      st_ff.setup <= bcs_pkg::SETUP_RESET;
      st_ff.test <= bcs_pkg::TEST_RESET;
      st_ff.ac0 <= bcs_pkg::AC0_RESET;
      st_ff.ac1 <= bcs_pkg::AC1_RESET;
      st_ff.dac0_out <= bcs_pkg::DAC_RESET;
      st_ff.dac1_out <= bcs_pkg::DAC_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cal_if.avg_valid = st_ff.avg_valid;
  assign cal_if.avg = st_ff.avg;
  assign cal_if.run = st_ff.run;
  assign cal_if.narrow = st_ff.setup[bcs_pkg::SETUP_NARROW];

  bcs_dac_calib u_calib (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cal(cal_if.eng)
  );

  bcs_rst_delay u_delay (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .conv_a_i(converter_clock_a_i),
    .conv_b_i(converter_clock_b_i),
    .sel_b_i(st_ff.ac0[bcs_pkg::AC0_CLK_SEL]),
    .delay_i(st_ff.ac1[bcs_pkg::AC1_PH_LSB +: 3]),
    .rtp_i(reset_timing_pair_i),
    .rtp_o(reset_timing_pair_o)
  );

  assign rd_data_o = st_ff.rd_data;
  assign first_offset_dac_o = st_ff.dac0_out;
  assign second_offset_dac_o = st_ff.dac1_out;
  assign data_o = st_ff.data;
  assign data_oe_o = st_ff.data_oe;
  assign frame_start_strobe_o = st_ff.frame_start_strobe;
  assign frame_start_strobe_oe_o = st_ff.fst_oe;
  assign qualifier_clock_o = st_ff.qualifier_clock;
  assign qualifier_clock_oe_o = st_ff.qck_oe;
  assign ana_ctrl_o = st_ff.ac0[5:0];
  assign array_read_strobe_a_o = st_ff.strobe_a;
  assign array_read_strobe_b_o = st_ff.strobe_b;
  assign dac0_double_current_o = st_ff.ac1[bcs_pkg::AC1_DBL];
  assign alt_pixel_readout_scheme_o = st_ff.ac1[bcs_pkg::AC1_ALT];
  assign dac1_high_gain_o = st_ff.ac1[bcs_pkg::AC1_HG];
  assign standby_o = st_ff.ac1[bcs_pkg::AC1_STBY];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_never;
    (acc_done && st_ff.setup[1:0] == 2'h0) |=> !cal_if.run && cal_if.avg_valid;
  endproperty
  a_never: assert property (p_never) else $error("calibration ran in never mode");

  property p_always;
    (acc_done && st_ff.setup[1:0] == 2'h1 && !standby_o) |=> cal_if.run;
  endproperty
  a_always: assert property (p_always) else $error("calibration skipped in always mode");

  property p_tri_hi;
    st_ff.test[bcs_pkg::TEST_TRI_HI] |=>
      data_oe_o[7:4] == 4'h0 && !frame_start_strobe_oe_o && !qualifier_clock_oe_o;
  endproperty
  a_tri_hi: assert property (p_tri_hi) else $error("upper outputs still driven");

  property p_tri_lo;
    st_ff.test[bcs_pkg::TEST_TRI_LO] |=> data_oe_o[3:0] == 4'h0;
  endproperty
  a_tri_lo: assert property (p_tri_lo) else $error("lower outputs still driven");

  property p_ext;
    st_ff.setup[bcs_pkg::SETUP_EXT] |=> first_offset_dac_o == $past(ext_dac0_i) &&
      second_offset_dac_o == $past(ext_dac1_i);
  endproperty
  a_ext: assert property (p_ext) else $error("external dac values not used");

  property p_autoinc;
    (wr_byte_i && !idx_wr_i && st_ff.inc) |=> st_ff.idx == $past(st_ff.idx) + 7'h01;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("index did not advance");

  property p_rsv_read;
    (rd_byte_i && !idx_wr_i && st_ff.idx == bcs_pkg::IDX_TEST) |=>
      (rd_data_o & ~bcs_pkg::TEST_MASK) == 8'h00;
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved bits read nonzero");

  property p_dac_read;
    (rd_byte_i && !idx_wr_i && st_ff.idx == bcs_pkg::IDX_DAC0) |=>
      rd_data_o == $past(cal_if.dac0);
  endproperty
  a_dac_read: assert property (p_dac_read) else $error("result read mismatch");

  property p_blank;
    (st_ff.ac0[bcs_pkg::AC0_BLANK_INH] && blank_line_i) |=> !array_read_strobe_a_o;
  endproperty
  a_blank: assert property (p_blank) else $error("strobe not suppressed");
endmodule : bcs_system_regs

//--- tb/bcs_host_model.sv
// serial host model driving the byte register port
`timescale 1ns/100ps
module bcs_host_model (
  // clock
  input wire logic clk_i,
  // byte port
  output logic idx_wr_o,
  output logic [7:0] idx_byte_o,
  output logic wr_byte_o,
  output logic [7:0] wr_data_o,
  output logic rd_byte_o,
  input wire logic [7:0] rd_data_i
);
  initial begin
    idx_wr_o = 1'b0;
    idx_byte_o = 8'h00;
    wr_byte_o = 1'b0;
    wr_data_o = 8'h00;
    rd_byte_o = 1'b0;
  end
  // released bytes are inverted so a stale value can never be taken by mistake
  task automatic send_index(input logic [7:0] b);
    @(posedge clk_i);
    #1;
    idx_byte_o = b;
    idx_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    idx_wr_o = 1'b0;
    idx_byte_o = ~b;
  endtask : send_index
  task automatic write_byte(input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_data_o = d;
    wr_byte_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_byte_o = 1'b0;
    wr_data_o = ~d;
  endtask : write_byte
  task automatic read_byte(output logic [7:0] d);
    @(posedge clk_i);
    #1;
    rd_byte_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_byte_o = 1'b0;
    d = rd_data_i;
  endtask : read_byte
endmodule : bcs_host_model

//--- tb/bcs_system_regs_tb.sv
// self-checking bench for the system register bank
`timescale 1ns/100ps
module bcs_system_regs_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic iw, wb, rb;
  logic [7:0] ib, wd, rd, vid, ext0, ext1, pix, data_o, data_oe, dac0, dac1, d;
  logic [2:0] gain;
  logic fs, qc, blank, sa, sb, ca, cb, inc;
  logic ls = 1'b0;
  logic bl = 1'b0;
  logic pv = 1'b0;
  logic [1:0] rtp, rtp_o;
  logic [5:0] ana;
  logic [9:0] misc;
  logic [6:0] cur, a;
  logic [7:0] regs [0:127];
  logic [6:0] sel [0:5] = '{7'h70, 7'h71, 7'h74, 7'h76, 7'h77, 7'h7f};
  int n_fail = 0;
  int num_checks = 0;

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  bcs_host_model host (.clk_i, .idx_wr_o(iw), .idx_byte_o(ib), .wr_byte_o(wb),
    .wr_data_o(wd), .rd_byte_o(rb), .rd_data_i(rd));

  bcs_system_regs DUT (.clk_i, .rst_i, .idx_wr_i(iw), .idx_byte_i(ib), .wr_byte_i(wb),
    .wr_data_i(wd), .rd_byte_i(rb), .rd_data_o(rd), .line_start_i(ls),
    .black_line_i(bl), .pix_valid_i(pv), .pix_i(pix), .gain_i(gain),
    .ext_dac0_i(ext0), .ext_dac1_i(ext1), .first_offset_dac_o(dac0),
    .second_offset_dac_o(dac1), .vid_data_i(vid), .frame_start_strobe_i(fs),
    .qualifier_clock_i(qc), .data_o(data_o), .data_oe_o(data_oe),
    .frame_start_strobe_o(misc[9]), .frame_start_strobe_oe_o(misc[8]),
    .qualifier_clock_o(misc[7]), .qualifier_clock_oe_o(misc[6]),
    .blank_line_i(blank), .array_read_strobe_a_i(sa), .array_read_strobe_b_i(sb),
    .ana_ctrl_o(ana), .array_read_strobe_a_o(misc[5]), .array_read_strobe_b_o(misc[4]),
    .dac0_double_current_o(misc[0]), .alt_pixel_readout_scheme_o(misc[1]),
    .dac1_high_gain_o(misc[2]), .standby_o(misc[3]), .converter_clock_a_i(ca),
    .converter_clock_b_i(cb), .reset_timing_pair_i(rtp), .reset_timing_pair_o(rtp_o));

  task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : check_val

  function automatic logic [7:0] wmask(input logic [6:0] i);
    case (i)
      7'h70: wmask = bcs_pkg::SETUP_MASK;
      7'h74: wmask = bcs_pkg::TEST_MASK;
      7'h76: wmask = bcs_pkg::AC0_MASK;
      7'h77: wmask = bcs_pkg::AC1_MASK;
      default: wmask = 8'h00;
    endcase
  endfunction : wmask

  task automatic put_idx(input logic [7:0] b);
    host.send_index(b);
    cur = b[6:0];
    inc = b[7];
  endtask : put_idx

  // model keeps read-only, reserved and unmapped places unchanged
  task automatic put(input logic [7:0] v);
    host.write_byte(v);
    regs[cur] = (regs[cur] & ~wmask(cur)) | (v & wmask(cur));
    cur = cur + 7'(inc);
  endtask : put

  task automatic get();
    logic [7:0] g;
    host.read_byte(g);
    check_val("rd", 16'(regs[cur]), 16'(g));
    cur = cur + 7'(inc);
  endtask : get

  task automatic stim();
    {vid, ext0, ext1, pix} = $urandom;
    {gain, fs, qc, blank, sa, sb, ca, cb, rtp} = 12'($urandom);
  endtask : stim

  // inputs held over two edges so every one-cycle path has settled
  task automatic check_pins();
    logic [7:0] t, a0, a1;
    t = regs[7'h74];
    a0 = regs[7'h76];
    a1 = regs[7'h77];
    @(posedge clk_i);
    #1;
    stim();
    repeat (2) @(posedge clk_i);
    #1;
    check_val("data", 16'(vid), 16'(data_o));
    check_val("data_oe", 16'({{4{~t[1]}}, {4{~t[3]}}}), 16'(data_oe));
    check_val("strobes", 16'({fs, ~t[1], qc, ~t[1]}), 16'(misc[9:6]));
    check_val("ana", 16'(a0[5:0]), 16'(ana));
    check_val("arr", 16'({sa, sb} & {2{~(a0[5] & blank)}}), 16'(misc[5:4]));
    check_val("ac1", 16'(a1[3:0]), 16'(misc[3:0]));
    check_val("dacs", regs[7'h70][6] ? {ext0, ext1} : 16'h8080, {dac0, dac1});
    if (a1[7:5] == 3'h0) begin
      check_val("rtp", 16'(rtp), 16'(rtp_o));
    end
  endtask : check_pins

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end

  initial begin
    for (int i = 0; i < 128; i++) begin
      regs[i] = 8'h00;
    end
    regs[7'h70] = bcs_pkg::SETUP_RESET;
    regs[7'h71] = bcs_pkg::DAC_RESET;
    regs[7'h72] = bcs_pkg::DAC_RESET;
    void'($urandom(12));
    stim();
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    // sweep crosses the unmapped holes at 73 and 75
    put_idx(8'hf0);
    repeat (8) get();
    $display("test reset_values done");
    for (int k = 0; k < 24; k++) begin
      a = sel[k % 6];
      put_idx({1'b0, a});
      d = 8'($urandom);
      if (a == 7'h70) begin
        d[1:0] = 2'b01;
      end
      if (a == 7'h74 && d[1]) begin
        d[3] = 1'b0;
      end
      put(d);
      get();
      get();
      check_pins();
    end
    $display("test random_writes done");
    put_idx(8'hf6);
    put(8'($urandom));
    put(8'($urandom));
    put_idx(8'hf1);
    repeat (3) get();
    check_pins();
    $display("test auto_increment done");
    // standby off and trigger always, or the engine would skip the line
    put_idx(8'h77);
    put(8'h00);
    put_idx(8'h70);
    put(8'h01);
    @(posedge clk_i);
    #1;
    ls = 1'b1;
    bl = 1'b1;
    pix = 8'hc8;
    @(posedge clk_i);
    #1;
    ls = 1'b0;
    pv = 1'b1;
    repeat (146) @(posedge clk_i);
    #1;
    pv = 1'b0;
    bl = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    // a bright average drops the top trial bit and tries the next one
    regs[7'h71] = 8'h40;
    check_val("dac0_pin", 16'h0040, 16'(dac0));
    check_val("dac1_pin", 16'h0080, 16'(dac1));
    put_idx(8'h71);
    get();
    $display("test black_line done");
    report_and_stop();
  end
endmodule : bcs_system_regs_tb
